// ==== src/dhb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "dhb_params.svh"
module dhb_top #(
	parameter int LOAD_CYC =
		`DHB_LOAD_MS * `DHB_NS_PER_MS / `DHB_CLK_NS,
	parameter int WAKE_CYC =
		`DHB_WAKE_MS * `DHB_NS_PER_MS / `DHB_CLK_NS,
	parameter int SLEEP_CYC =
		`DHB_SLEEP_MS * `DHB_NS_PER_MS / `DHB_CLK_NS,
	parameter int FIFO_DEPTH = `DHB_FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic pixel_clock,
	input wire logic hw_reset_n,
	input wire logic chip_sel_n,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic cmd_data_sel,
	input wire logic [`DHB_BUS_W-1:0] bus_in,
	output logic [`DHB_BUS_W-1:0] bus_out,
	output logic bus_oe_n,
	input wire logic pixel_de,
	input wire dhb_pkg::dhb_pix_t pixel_data,
	input wire logic awake_mode,
	input wire dhb_pkg::dhb_nv_t nv_in,
	input wire logic [`DHB_BUS_W-1:0] rd_word,
	output dhb_pkg::dhb_word_t word_out,
	output logic word_valid,
	input wire logic word_ready,
	output logic write_busy,
	output dhb_pkg::dhb_pix_t pix_out,
	output logic pix_valid,
	output logic pix_overrun,
	output dhb_pkg::dhb_nv_t nv_regs,
	output logic dev_reset,
	output logic nv_loading,
	output logic display_blank,
	output logic settings_default,
	output logic cmd_ready
);
	import dhb_pkg::*;

	localparam int SPIKE_CYC =
		(`DHB_SPIKE_NS + `DHB_CLK_NS - 1) / `DHB_CLK_NS;

	if (LOAD_CYC < 1 || LOAD_CYC >= WAKE_CYC || SLEEP_CYC < LOAD_CYC
		|| WAKE_CYC >= (1 << `DHB_CNT_W)
		|| SPIKE_CYC >= (1 << `DHB_SPK_W)) begin : g_chk
		$error("dhb_top timing parameters out of range");
	end

	function automatic logic [`DHB_SPK_W-1:0] sat_inc(
		input logic [`DHB_SPK_W-1:0] v);
		sat_inc = (v == `DHB_SPK_W'(SPIKE_CYC)) ? v : v + `DHB_SPK_W'(1);
	endfunction : sat_inc

	// Reset pin synchroniser; only the second stage is read.
	logic rst_s1;
	logic rst_s2;
	logic [`DHB_SPK_W-1:0] low_cnt;
	logic [`DHB_SPK_W-1:0] high_cnt;
	logic rst_filt;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1 <= 1'b1;
			rst_s2 <= 1'b1;
		end else begin
			rst_s1 <= hw_reset_n;
			rst_s2 <= rst_s1;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			low_cnt <= '0;
			high_cnt <= '0;
		end else begin
			low_cnt <= rst_s2 ? '0 : sat_inc(low_cnt);
			high_cnt <= rst_s2 ? sat_inc(high_cnt) : '0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			// A local reset behaves like a pin reset that is still held.
			rst_filt <= 1'b1;
		end else if (!rst_filt) begin
			rst_filt <= (low_cnt == `DHB_SPK_W'(SPIKE_CYC));
		end else begin
			rst_filt <= (high_cnt != `DHB_SPK_W'(SPIKE_CYC));
		end
	end

	// Reset sequencing; the counter measures time since the pin rose.
	dhb_state_t state;
	logic [`DHB_CNT_W-1:0] seq_cnt;
	logic was_awake;
	logic [`DHB_CNT_W-1:0] cancel_end;

	assign cancel_end = was_awake ? `DHB_CNT_W'(WAKE_CYC)
		: `DHB_CNT_W'(SLEEP_CYC);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state <= DHB_HOLD;
			seq_cnt <= '0;
			was_awake <= 1'b0;
		end else begin
			case (state)
				DHB_RUN: begin
					if (rst_filt) begin
						state <= DHB_HOLD;
						was_awake <= awake_mode;
					end
				end
				DHB_HOLD: begin
					if (!rst_filt) begin
						state <= DHB_LOAD;
						seq_cnt <= `DHB_CNT_W'(SPIKE_CYC);
					end
				end
				DHB_LOAD: begin
					seq_cnt <= seq_cnt + `DHB_CNT_W'(1);
					if (rst_filt) begin
						state <= DHB_HOLD;
					end else if (seq_cnt >= `DHB_CNT_W'(LOAD_CYC - 1)) begin
						state <= DHB_CANCEL;
					end
				end
				DHB_CANCEL: begin
					seq_cnt <= seq_cnt + `DHB_CNT_W'(1);
					if (rst_filt) begin
						state <= DHB_HOLD;
					end else if (seq_cnt >= cancel_end - `DHB_CNT_W'(1)) begin
						state <= DHB_RUN;
					end
				end
				default: begin
					state <= DHB_HOLD;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			nv_regs <= '0;
			nv_loading <= 1'b0;
		end else begin
			nv_loading <= (state == DHB_LOAD)
				&& (seq_cnt < `DHB_CNT_W'(LOAD_CYC - 1));
			if (state == DHB_LOAD && seq_cnt >= `DHB_CNT_W'(LOAD_CYC - 1)) begin
				nv_regs <= nv_in;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			display_blank <= 1'b1;
			settings_default <= 1'b0;
			dev_reset <= 1'b1;
			cmd_ready <= 1'b0;
		end else begin
			display_blank <= (state != DHB_RUN) || !awake_mode;
			settings_default <= (state == DHB_CANCEL) && !rst_filt
				&& (seq_cnt >= cancel_end - `DHB_CNT_W'(1));
			dev_reset <= (state == DHB_HOLD);
			cmd_ready <= (state == DHB_RUN);
		end
	end

	// Parallel bus pins cross into sys_clk through two stages each.
	dhb_word_t bus_s1;
	dhb_word_t bus_s2;
	logic [2:0] ctl_s1;
	logic [2:0] ctl_s2;
	logic wr_prev;
	dhb_word_t wr_hold;
	logic push;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	dhb_word_t fifo_out;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			bus_s1 <= '0;
			bus_s2 <= '0;
			ctl_s1 <= 3'h7;
			ctl_s2 <= 3'h7;
			wr_prev <= 1'b1;
			wr_hold <= '0;
		end else begin
			bus_s1 <= {cmd_data_sel, bus_in};
			bus_s2 <= bus_s1;
			ctl_s1 <= {chip_sel_n, write_strobe_n, read_strobe_n};
			ctl_s2 <= ctl_s1;
			wr_prev <= ctl_s2[1];
			// Data is held while the strobe is low, since its hold time
			// after the rising edge is far shorter than the sync delay.
			if (!ctl_s2[1]) begin
				wr_hold <= bus_s2;
			end
		end
	end

	assign push = ctl_s2[1] && !wr_prev && !ctl_s2[2]
		&& (state == DHB_RUN);

	dhb_fifo #(
		.WIDTH($bits(dhb_word_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(sys_clk),
		.rstn(rstn),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(wr_hold),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out)
	);

	assign fifo_out_ready = !word_valid || word_ready;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			word_out <= '0;
			word_valid <= 1'b0;
			write_busy <= 1'b0;
		end else begin
			write_busy <= !fifo_in_ready;
			if (fifo_out_ready) begin
				word_valid <= fifo_out_valid;
				word_out <= fifo_out;
			end
		end
	end

	// Read data is driven while both select and read strobe are low and commands are taken.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			bus_out <= '0;
			bus_oe_n <= 1'b1;
		end else begin
			bus_out <= rd_word;
			bus_oe_n <= ctl_s2[2] || ctl_s2[0] || (state != DHB_RUN);
		end
	end

	// Pixel port: a toggle handshake carries each word into sys_clk.
	// A word arriving before the previous one is taken is dropped and
	// flagged, since the video source cannot be stalled.
	dhb_pix_t pix_hold;
	logic pix_req;
	logic ack_p1;
	logic ack_p2;
	logic pix_drop;
	logic pix_ack;
	logic req_s1;
	logic req_s2;
	logic req_s3;
	logic drop_s1;
	logic drop_s2;

	always_ff @(posedge pixel_clock or negedge rstn) begin
		if (!rstn) begin
			ack_p1 <= 1'b0;
			ack_p2 <= 1'b0;
		end else begin
			ack_p1 <= pix_ack;
			ack_p2 <= ack_p1;
		end
	end

	always_ff @(posedge pixel_clock or negedge rstn) begin
		if (!rstn) begin
			pix_hold <= '0;
			pix_req <= 1'b0;
			pix_drop <= 1'b0;
		end else if (pixel_de) begin
			if (pix_req == ack_p2) begin
				pix_hold <= pixel_data;
				pix_req <= !pix_req;
			end else begin
				pix_drop <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			req_s3 <= 1'b0;
			drop_s1 <= 1'b0;
			drop_s2 <= 1'b0;
		end else begin
			req_s1 <= pix_req;
			req_s2 <= req_s1;
			req_s3 <= req_s2;
			drop_s1 <= pix_drop;
			drop_s2 <= drop_s1;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pix_out <= '0;
			pix_valid <= 1'b0;
			pix_ack <= 1'b0;
			pix_overrun <= 1'b0;
		end else begin
			pix_valid <= (req_s2 != req_s3);
			pix_overrun <= drop_s2;
			if (req_s2 != req_s3) begin
				pix_out <= pix_hold;
				pix_ack <= req_s2;
			end
		end
	end
endmodule : dhb_top
`default_nettype wire

// ==== pkg/dhb_params.svh ====
// Overview of operation
// - Reject reset lows under 5us, accept longer.
// - Glitches inside a held reset are ignored.
// - Reload stored settings within 5 ms after release.
// - Blank display while resetting, then restore defaults.
// - Reset from awake mode finishes within 120 ms.
// - Reset from sleep mode finishes within 5 ms.
// - Select high means data, low means command.
`ifndef DHB_PARAMS_SVH
`define DHB_PARAMS_SVH
`define DHB_CLK_NS 8
`define DHB_SPIKE_NS 5000
`define DHB_LOAD_MS 5
`define DHB_WAKE_MS 120
`define DHB_SLEEP_MS 5
`define DHB_NS_PER_MS 1000000
`define DHB_BUS_W 18
`define DHB_FIFO_DEPTH 4
`define DHB_CNT_W 24
`define DHB_SPK_W 11
`endif

// ==== pkg/dhb_pkg.sv ====
package dhb_pkg;
	typedef struct packed {
		logic dc;
		logic [17:0] data;
	} dhb_word_t;
	typedef struct packed {
		logic [17:0] data;
	} dhb_pix_t;
	typedef struct packed {
		logic [23:0] id;
		logic [7:0] common_voltage_setting;
	} dhb_nv_t;
	typedef enum logic [1:0] {
		DHB_RUN,
		DHB_HOLD,
		DHB_LOAD,
		DHB_CANCEL
	} dhb_state_t;
endpackage : dhb_pkg

// ==== src/dhb_fifo.sv ====
`timescale 1ns/1ns
`default_nettype none
module dhb_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("dhb_fifo depth must be a power of two of at least 2");
	end

	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + AW'(1);
			end
			if (pop) begin
				rd_ptr <= rd_ptr + AW'(1);
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : dhb_fifo
`default_nettype wire

// ==== tb/dhb_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module dhb_chk #(
	parameter int LOAD_CYC = 50,
	parameter int WAKE_CYC = 200,
	parameter int SLEEP_CYC = 80
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic hw_reset_n,
	input wire logic awake_mode,
	input wire dhb_pkg::dhb_nv_t nv_in,
	input wire dhb_pkg::dhb_nv_t nv_regs,
	input wire logic dev_reset,
	input wire logic nv_loading,
	input wire logic display_blank,
	input wire logic settings_default,
	input wire logic cmd_ready
);
	import dhb_pkg::*;
	logic [10:0] lo_cnt;
	logic [10:0] hi_cnt;
	logic wk;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	// Pin run lengths saturate, so a long idle never wraps to a match.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			lo_cnt <= 11'h000;
		else
			lo_cnt <= hw_reset_n ? 11'h000 : lo_cnt + {10'h000, ~&lo_cnt};
	end
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			hi_cnt <= 11'h000;
		else
			hi_cnt <= !hw_reset_n ? 11'h000 : hi_cnt + {10'h000, ~&hi_cnt};
	end
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			wk <= 1'h0;
		else if ($rose(dev_reset))
			wk <= awake_mode;
	end
	sequence s_ready;
		##[0:2] cmd_ready;
	endsequence
	property p_spike;
		$rose(dev_reset) |-> lo_cnt >= 11'h271;
	endproperty
	property p_full;
		lo_cnt == 11'h4E2 |-> dev_reset;
	endproperty
	property p_glitch;
		dev_reset && hi_cnt < 11'h258 |=> dev_reset;
	endproperty
	property p_reload;
		!dev_reset && hi_cnt == LOAD_CYC + 12 |-> !nv_loading && nv_regs == nv_in;
	endproperty
	property p_blank;
		dev_reset || nv_loading |-> display_blank && !cmd_ready;
	endproperty
	property p_end;
		settings_default |-> s_ready;
	endproperty
	property p_wake;
		wk && !dev_reset && hi_cnt == WAKE_CYC + 12 |-> cmd_ready;
	endproperty
	property p_sleep;
		!wk && !dev_reset && hi_cnt == SLEEP_CYC + 12 |-> cmd_ready;
	endproperty
	a_spike: assert property (p_spike)
		else $error("reset taken from a short low");
	a_full: assert property (p_full)
		else $error("long low did not reset");
	a_glitch: assert property (p_glitch)
		else $error("short high ended reset");
	a_reload: assert property (p_reload)
		else $error("settings not loaded in time");
	a_blank: assert property (p_blank)
		else $error("display not blank in reset");
	a_end: assert property (p_end)
		else $error("defaults without ready");
	a_wake: assert property (p_wake)
		else $error("awake cancel too long");
	a_sleep: assert property (p_sleep)
		else $error("sleep cancel too long");
endmodule : dhb_chk
bind dhb_top dhb_chk #(
	.LOAD_CYC(LOAD_CYC),
	.WAKE_CYC(WAKE_CYC),
	.SLEEP_CYC(SLEEP_CYC)
) dhb_chk_inst (
	.sys_clk(sys_clk), .rstn(rstn), .hw_reset_n(hw_reset_n),
	.awake_mode(awake_mode), .nv_in(nv_in), .nv_regs(nv_regs),
	.dev_reset(dev_reset), .nv_loading(nv_loading),
	.display_blank(display_blank), .cmd_ready(cmd_ready),
	.settings_default(settings_default)
);
`default_nettype wire

// ==== tb/dhb_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module dhb_host (
	input wire logic clk,
	input wire logic [17:0] bus_out,
	input wire logic bus_oe_n,
	output logic hw_reset_n,
	output logic chip_sel_n,
	output logic write_strobe_n,
	output logic read_strobe_n,
	output logic cmd_data_sel,
	output logic [17:0] bus_in,
	output logic pixel_clock,
	output logic pixel_de,
	output dhb_pkg::dhb_pix_t pixel_data
);
	import dhb_pkg::*;
	initial begin
		{hw_reset_n, chip_sel_n, write_strobe_n, read_strobe_n} = 4'hF;
		{cmd_data_sel, pixel_clock, pixel_de} = 3'h0;
		bus_in = 18'h0;
		pixel_data = 18'h0;
	end
	task automatic hrst(input int n);
		@(posedge clk) hw_reset_n <= 1'h0;
		repeat (n) @(posedge clk);
		hw_reset_n <= 1'h1;
	endtask : hrst
	task automatic wr(input logic dc, input logic [17:0] d);
		@(posedge clk);
		chip_sel_n <= 1'h0;
		cmd_data_sel <= dc;
		bus_in <= d;
		write_strobe_n <= 1'h0;
		repeat (4) @(posedge clk);
		write_strobe_n <= 1'h1;
		repeat (2) @(posedge clk);
		chip_sel_n <= 1'h1;
		bus_in <= ~d;
		repeat (3) @(posedge clk);
	endtask : wr
	// read, low and high time in clocks
	task automatic rd(input int lo, input int hi, output logic oe,
		output logic [17:0] d);
		@(posedge clk);
		chip_sel_n <= 1'h0;
		read_strobe_n <= 1'h0;
		repeat (lo) @(posedge clk);
		oe = bus_oe_n;
		d = bus_out;
		read_strobe_n <= 1'h1;
		chip_sel_n <= 1'h1;
		repeat (hi) @(posedge clk);
	endtask : rd
	// 18-bit mode, 64 ns period, enable every s clocks
	task automatic pix(input int n, input int s, input logic [17:0] b);
		#3;
		for (int i = 0; i < n; i++) begin
			pixel_de = (i % s == 0);
			pixel_data = b + 18'(i);
			#32 pixel_clock = 1'h1;
			#32 pixel_clock = 1'h0;
		end
		pixel_de = 1'h0;
	endtask : pix
endmodule : dhb_host
`default_nettype wire

// ==== tb/dhb_top_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module dhb_top_tb_top;
	import dhb_pkg::*;
	localparam int LD = 700, SL = 800, WK = 1200;
	logic sys_clk = 1'h0, rstn = 1'h0, awake_mode = 1'h0, word_ready = 1'h0;
	logic [17:0] rd_word = 18'h2A5C3;
	dhb_nv_t nv_in = 32'hA1B2C3D4;
	logic pixel_clock, hw_reset_n, chip_sel_n, write_strobe_n, read_strobe_n;
	logic cmd_data_sel, bus_oe_n, pixel_de, word_valid, write_busy, pix_valid;
	logic pix_overrun, dev_reset, nv_loading, display_blank;
	logic settings_default, cmd_ready, oe;
	logic [17:0] bus_w, host_bus, bus_out, d;
	dhb_pix_t pixel_data, pix_out;
	dhb_nv_t nv_regs;
	dhb_word_t word_out, wq[$];
	logic [17:0] pq[$];
	int err_total = 0, total_checks = 0, n;
	// Bus wire: the device wins while its drive enable is low.
	assign bus_w = !bus_oe_n ? bus_out : host_bus;
	always #4 sys_clk = ~sys_clk;
	dhb_top #(.LOAD_CYC(LD), .WAKE_CYC(WK), .SLEEP_CYC(SL)) dhb_top_inst (
		.sys_clk, .rstn, .pixel_clock, .hw_reset_n, .chip_sel_n,
		.write_strobe_n, .read_strobe_n, .cmd_data_sel, .bus_in(bus_w),
		.bus_out, .bus_oe_n, .pixel_de, .pixel_data, .awake_mode, .nv_in,
		.rd_word, .word_out, .word_valid, .word_ready, .write_busy, .pix_out,
		.pix_valid, .pix_overrun, .nv_regs, .dev_reset, .nv_loading,
		.display_blank, .settings_default, .cmd_ready
	);
	dhb_host dhb_host_inst (
		.clk(sys_clk), .bus_out, .bus_oe_n, .hw_reset_n, .chip_sel_n,
		.write_strobe_n, .read_strobe_n, .cmd_data_sel, .bus_in(host_bus),
		.pixel_clock, .pixel_de, .pixel_data
	);
	always @(posedge sys_clk) begin
		if (word_valid === 1'h1 && word_ready === 1'h1)
			wq.push_back(word_out);
		if (pix_valid === 1'h1)
			pq.push_back(pix_out.data);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict
	// Counts clocks until commands are taken, with a bound.
	task automatic wait_rdy(output int c);
		c = 0;
		while (cmd_ready !== 1'h1 && c < 3000) begin
			@(posedge sys_clk);
			c++;
		end
	endtask : wait_rdy
	task automatic t_spike;
		dhb_host_inst.hrst(400);
		repeat (700) @(posedge sys_clk);
		chk(dev_reset, 1'h0);
		chk(cmd_ready, 1'h1);
		$display("t_spike done");
	endtask : t_spike
	task automatic t_glitch;
		dhb_host_inst.hrst(1300);
		chk(dev_reset, 1'h1);
		nv_in <= 32'h5E6F7081;
		repeat (300) @(posedge sys_clk);
		chk(dev_reset, 1'h1);
		dhb_host_inst.hrst(200);
		wait_rdy(n);
		chk(n >= SL && n <= SL + 12, 1'h1);
		chk(nv_regs, 32'h5E6F7081);
		chk(display_blank, 1'h1);
		$display("t_glitch done");
	endtask : t_glitch
	task automatic t_wake;
		// sleep exit waits the awake bound
		repeat (WK - SL) @(posedge sys_clk);
		awake_mode <= 1'h1;
		dhb_host_inst.hrst(1300);
		chk(display_blank, 1'h1);
		dhb_host_inst.rd(6, 14, oe, d);
		chk(oe, 1'h1);
		wait_rdy(n);
		// The read above already spent 21 clocks of the cancel period.
		chk(n + 21 >= WK && n + 21 <= WK + 12, 1'h1);
		repeat (2) @(posedge sys_clk);
		chk(display_blank, 1'h0);
		$display("t_wake done");
	endtask : t_wake
	task automatic t_write;
		// writes only once commands are taken
		for (int i = 0; i < 6; i++)
			dhb_host_inst.wr(i[0], 18'h100 + 18'(i));
		chk(write_busy, 1'h1);
		word_ready <= 1'h1;
		repeat (20) @(posedge sys_clk);
		chk(wq.size(), 5);
		for (int i = 0; i < 5; i++)
			chk(wq[i], {i[0], 18'h100 + 18'(i)});
		$display("t_write done");
	endtask : t_write
	task automatic t_read;
		dhb_host_inst.rd(6, 14, oe, d);
		chk(oe, 1'h0);
		chk(d, 18'h2A5C3);
		chk(bus_oe_n, 1'h1);
		rd_word <= 18'h15A3C;
		dhb_host_inst.rd(45, 12, oe, d);
		chk(oe, 1'h0);
		chk(d, 18'h15A3C);
		$display("t_read done");
	endtask : t_read
	task automatic t_pix;
		// Three clocks apart, so the handshake is back before each word.
		dhb_host_inst.pix(10, 3, 18'h3F00);
		repeat (10) @(posedge sys_clk);
		chk(pq.size(), 4);
		for (int i = 0; i < 4; i++)
			chk(pq[i], 18'h3F00 + 18'(3 * i));
		chk(pix_overrun, 1'h0);
		dhb_host_inst.pix(3, 1, 18'h0);
		repeat (10) @(posedge sys_clk);
		chk(pix_overrun, 1'h1);
		$display("t_pix done");
	endtask : t_pix
	initial begin
		repeat (8) @(posedge sys_clk);
		rstn <= 1'h1;
		wait_rdy(n);
		t_spike();
		t_glitch();
		t_wake();
		t_write();
		t_read();
		t_pix();
		print_verdict();
	end
	initial begin
		#200000;
		err_total++;
		print_verdict();
	end
endmodule : dhb_top_tb_top
`default_nettype wire
